/* pkg/ocs_pkg.sv */
// shared constants, types and helpers for the oscillator source switch
package ocs_pkg;

  // clock rates in hertz
  localparam int unsigned OCS_PCLK_HZ = 200_000_000; // system sampling clock
  localparam int unsigned OCS_INT_OSC_HZ = 12_800_000; // nominal internal oscillator
  localparam int unsigned OCS_BUS_DIV = 4; // bus clock is full-rate over four

  // internal oscillator half period in pclk cycles, rounded down
  localparam int unsigned OCS_INT_HALF_CYC = OCS_PCLK_HZ / (2 * OCS_INT_OSC_HZ);
  // trim bits that steer the period model (top bits only, coarse model)
  localparam int unsigned OCS_TRIM_SHIFT = 5;
  localparam logic [7:0] OCS_TRIM_RST = 8'h80; // midpoint trim
  // base so that the midpoint trim gives the nominal half period
  localparam logic [3:0] OCS_TRIM_BASE =
    4'(OCS_INT_HALF_CYC - (int'(OCS_TRIM_RST) >> OCS_TRIM_SHIFT));

  // register byte offsets
  localparam logic [7:0] OCS_TRIM_OFS = 8'h38; // internal_osc_trim
  localparam logic [7:0] OCS_STAT_OFS = 8'h3C; // oscillator_status_reg
  localparam logic [7:0] OCS_CFG_OFS = 8'h40; // config_word_two
  localparam logic [7:0] OCS_PUE_OFS = 8'h44; // port_a_pullup_enable_reg

  // field positions
  localparam int unsigned OCS_STAT_REQ = 0; // external_clock_request
  localparam int unsigned OCS_STAT_ENG = 1; // external_clock_engaged
  localparam int unsigned OCS_PUE_CKO = 0; // second_pin_clock_out_enable

  // reset values
  localparam logic [1:0] OCS_CFG_RST = 2'h0;
  localparam logic [31:0] OCS_RDATA_ZERO = 32'h0000_0000;

  // rising external edges needed before the switch
  localparam logic [1:0] OCS_EDGES_NEEDED = 2'h2;

  // clock_source_select encodings
  typedef enum logic [1:0] {
    OCS_SRC_INT = 2'b00,
    OCS_SRC_EXT = 2'b01,
    OCS_SRC_RC = 2'b10,
    OCS_SRC_XTAL = 2'b11
  } ocs_src_t;

  // switch sequencer states
  typedef enum logic [2:0] {
    OCS_ST_INT = 3'b000,
    OCS_ST_WAIT = 3'b001,
    OCS_ST_ALIGN = 3'b010,
    OCS_ST_ENGAGE = 3'b011,
    OCS_ST_EXT = 3'b100
  } ocs_sw_state_t;

  // one driven pin: level and enable
  typedef struct packed {
    logic out;
    logic oe;
  } ocs_pin_t;

  // any source other than the internal oscillator
  function automatic logic ocs_is_external(input ocs_src_t src);
    return src != OCS_SRC_INT;
  endfunction

endpackage

/* rtl/ocs_int_osc.sv */
// trimmable internal oscillator model, counted in pclk cycles
module ocs_int_osc
  import ocs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [7:0] trim,
  output logic osc_clk
);

  logic [3:0] cnt_q; // cycles spent in the current half period
  logic clk_q; // oscillator level
  logic [3:0] half_cyc; // half period for this trim
  logic wrap; // half period done

  // larger trim never shortens the period; top bits only, so steps are coarse
  assign half_cyc = OCS_TRIM_BASE + {1'b0, trim[7:OCS_TRIM_SHIFT]}; // RL4 RL3
  assign wrap = (cnt_q >= (half_cyc - 4'h1));

  // stopped oscillator parks low so the downstream mux sees no half pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      clk_q <= 1'b0;
    end else if (!enable) begin
      cnt_q <= 4'h0;
      clk_q <= 1'b0;
    end else if (wrap) begin
      cnt_q <= 4'h0;
      clk_q <= ~clk_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end

  assign osc_clk = clk_q;

endmodule

/* rtl/ocs_osc_switch.sv */
// oscillator source select, glitch-free switch, clock outputs and pin mux
// Summary of operation
// RL1 - bus clock is full-rate divided by four
// RL2 - reset selects the internal oscillator
// RL3 - internal oscillator nominal 12.8 MHz
// RL4 - 8-bit trim, larger value longer period
// RL5 - reset loads trim with 0x80
// RL6 - software may copy factory trim byte
// RL7 - software precharges crystal via second pin
// RL8 - external select makes pins clock pins
// RL9 - software waits for external source stabilisation
// RL10 - software sets request bit to switch
// RL11 - wait two external rising edges first
// RL12 - switch without glitches or short pulses
// RL13 - set engaged flag, then stop internal
// RL14 - no fallback; only reset restarts internal
// RL15 - direct external: unchanged, half-rate halved
// RL16 - direct external: second pin is port bit
// RL17 - crystal: second pin is amplifier output
// RL18 - internal/RC: enable bit picks port or clock
// RL19 - select code 00 int,01 ext,10 RC,11 xtal
// RL20 - reset clears the request bit
// RL21 - stop mode halts both clock outputs
// RL22 - after engaged, request writes are ignored
//
// Register access over APB was left to the implementer.
module ocs_osc_switch
  import ocs_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clock_input_pin,
  input wire logic port_a_bit_four_out,
  input wire logic port_a_bit_four_oe,
  input wire logic stop_mode,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe,
  output logic clock_input_pin_is_clock,
  output logic internal_osc_run,
  output logic full_rate_clock,
  output logic half_rate_clock,
  output logic bus_clock,
  output logic external_clock_engaged
);

  // apb bus state
  logic [31:0] prdata_q, prdata_d; // read data, loaded in setup
  logic pready_q; // one access cycle, no waits
  logic pslverr_q; // unmapped address answer
  // software registers
  logic [7:0] trim_q; // internal_osc_trim
  ocs_src_t src_q; // clock_source_select
  logic cko_en_q; // second_pin_clock_out_enable
  logic req_q; // external_clock_request
  // switch sequencer
  ocs_sw_state_t state_q, state_d;
  logic [1:0] edge_cnt_q; // external rising edges seen
  logic ext_prev_q; // last external level, for edges
  logic sel_ext_q; // mux steers external source
  logic engaged_q; // external_clock_engaged
  logic int_run_q; // internal oscillator enable
  // clock outputs
  logic full_q, half_q, bus_q;
  ocs_pin_t pin_q, pin_d; // second oscillator pin
  logic pin1_clk_q; // first pin used as clock input
  logic int_clk; // internal oscillator level

  // decode wires
  wire setup = psel & ~penable;
  wire access = psel & penable & pready_q;
  wire hit_trim = (paddr == OCS_TRIM_OFS);
  wire hit_stat = (paddr == OCS_STAT_OFS);
  wire hit_cfg = (paddr == OCS_CFG_OFS);
  wire hit_pue = (paddr == OCS_PUE_OFS);
  wire hit_any = hit_trim | hit_stat | hit_cfg | hit_pue;
  wire wr_ok = access & pwrite & ~pslverr_q;
  wire wr_trim = wr_ok & hit_trim;
  wire wr_stat = wr_ok & hit_stat;
  wire wr_cfg = wr_ok & hit_cfg;
  wire wr_pue = wr_ok & hit_pue;
  wire ext_rise = clock_input_pin & ~ext_prev_q;
  wire src_is_ext = ocs_is_external(src_q);
  // both candidate sources low: safe moment to move the mux
  wire both_low = ~int_clk & ~clock_input_pin; // RL12
  wire full_src = sel_ext_q ? clock_input_pin : int_clk; // RL15
  wire full_d = ~stop_mode & full_src; // RL21
  wire full_rise = full_d & ~full_q;
  wire half_rise = ~half_q & full_rise;

  // internal oscillator; stays off once the external clock owns the system
  ocs_int_osc u_int_osc (
    .pclk(pclk),
    .presetn(presetn),
    .enable(int_run_q),
    .trim(trim_q),
    .osc_clk(int_clk)
  );

  // read mux, loaded during the setup cycle
  always_comb begin
    prdata_d = OCS_RDATA_ZERO;
    if (hit_trim) begin
      prdata_d[7:0] = trim_q;
    end else if (hit_stat) begin
      prdata_d[OCS_STAT_REQ] = req_q;
      prdata_d[OCS_STAT_ENG] = engaged_q;
    end else if (hit_cfg) begin
      prdata_d[1:0] = src_q;
    end else if (hit_pue) begin
      prdata_d[OCS_PUE_CKO] = cko_en_q;
    end
  end

  // apb handshake: pready rises in the access phase, one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= OCS_RDATA_ZERO;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit_any;
      if (setup & ~pwrite) begin
        prdata_q <= prdata_d;
      end
    end
  end

  // software registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_q <= OCS_TRIM_RST; // RL5
      src_q <= OCS_SRC_INT; // RL2 RL19
      cko_en_q <= 1'b0;
      req_q <= 1'b0; // RL20
    end else begin
      if (wr_trim) begin
        trim_q <= pwdata[7:0]; // RL6
      end
      if (wr_cfg) begin
        src_q <= ocs_src_t'(pwdata[1:0]); // RL19
      end
      if (wr_pue) begin
        cko_en_q <= pwdata[OCS_PUE_CKO];
      end
      // request locked once engaged
      if (wr_stat & ~engaged_q) begin
        req_q <= pwdata[OCS_STAT_REQ]; // RL10 RL22
      end
    end
  end

  // sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      OCS_ST_INT: begin
        // request only means something with an external source chosen
        if (req_q & src_is_ext) begin
          state_d = OCS_ST_WAIT;
        end
      end
      OCS_ST_WAIT: begin
        // withdrawn request or source returns to internal aborts
        if (~req_q | ~src_is_ext) begin
          state_d = OCS_ST_INT;
        end else if (ext_rise & (edge_cnt_q == OCS_EDGES_NEEDED - 2'h1)) begin
          state_d = OCS_ST_ALIGN; // RL11
        end
      end
      OCS_ST_ALIGN: begin
        if (both_low) begin
          state_d = OCS_ST_ENGAGE; // RL12
        end
      end
      OCS_ST_ENGAGE: begin
        state_d = OCS_ST_EXT;
      end
      OCS_ST_EXT: begin
        state_d = OCS_ST_EXT; // RL14
      end
      default: begin
        state_d = OCS_ST_INT;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= OCS_ST_INT;
      edge_cnt_q <= 2'h0;
      ext_prev_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ext_prev_q <= clock_input_pin;
      if (state_q != OCS_ST_WAIT) begin
        edge_cnt_q <= 2'h0;
      end else if (ext_rise) begin
        edge_cnt_q <= edge_cnt_q + 2'h1; // RL11
      end
    end
  end

  // mux select, engaged flag, internal oscillator stop in that order
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_ext_q <= 1'b0; // RL2
      engaged_q <= 1'b0;
      int_run_q <= 1'b1; // RL2
    end else begin
      if (state_q == OCS_ST_ALIGN && both_low) begin
        sel_ext_q <= 1'b1; // RL12
      end
      if (state_q == OCS_ST_ENGAGE) begin
        engaged_q <= 1'b1; // RL13
      end
      // a lost external clock is not watched: no way back but reset
      if (state_q == OCS_ST_EXT) begin
        int_run_q <= 1'b0; // RL13 RL14
      end
    end
  end

  // clock dividers driven by rising edges of the selected source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      full_q <= 1'b0;
      half_q <= 1'b0;
      bus_q <= 1'b0;
    end else begin
      full_q <= full_d; // RL15 RL21
      if (full_rise) begin
        half_q <= ~half_q; // RL15
      end
      if (half_rise) begin
        bus_q <= ~bus_q; // RL1
      end
    end
  end

  // second pin function per source; enable bit only counts for int/RC
  always_comb begin
    pin_d.out = port_a_bit_four_out;
    pin_d.oe = port_a_bit_four_oe;
    if (src_q == OCS_SRC_XTAL) begin
      pin_d.out = ~clock_input_pin; // RL17 RL8
      pin_d.oe = 1'b1;
    end else if (src_q == OCS_SRC_EXT) begin
      pin_d.out = port_a_bit_four_out; // RL16
      pin_d.oe = port_a_bit_four_oe;
    end else if (cko_en_q) begin
      pin_d.out = full_d; // RL18
      pin_d.oe = 1'b1;
    end
  end

  // pin registers; first pin turns clock input for any external source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_q <= '0;
      pin1_clk_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      pin1_clk_q <= src_is_ext; // RL8
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign clock_output_pin_o = pin_q.out;
  assign clock_output_pin_oe = pin_q.oe;
  assign clock_input_pin_is_clock = pin1_clk_q;
  assign internal_osc_run = int_run_q;
  assign full_rate_clock = full_q;
  assign half_rate_clock = half_q;
  assign bus_clock = bus_q;
  assign external_clock_engaged = engaged_q;

  // checks
  chk_trim_reset: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    $rose(presetn) |-> trim_q == OCS_TRIM_RST)
    else $error("trim not at midpoint after reset");
  chk_src_reset: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    $rose(presetn) |-> !sel_ext_q && int_run_q && src_q == OCS_SRC_INT)
    else $error("internal source not selected after reset");
  chk_req_reset: assert property (@(posedge pclk) disable iff (!presetn) // RL20
    $rose(presetn) |-> !req_q)
    else $error("request bit set after reset");
  chk_engage_order: assert property (@(posedge pclk) disable iff (!presetn) // RL13
    $rose(engaged_q) |-> int_run_q ##1 !int_run_q)
    else $error("internal oscillator stopped out of order");
  chk_no_fallback: assert property (@(posedge pclk) disable iff (!presetn) // RL14
    engaged_q |=> engaged_q && sel_ext_q && !int_run_q)
    else $error("left external source without reset");
  chk_two_edges: assert property (@(posedge pclk) disable iff (!presetn) // RL11
    state_q == OCS_ST_ALIGN && $past(state_q) == OCS_ST_WAIT |-> edge_cnt_q == OCS_EDGES_NEEDED)
    else $error("switched before two external edges");
  chk_glitch_free: assert property (@(posedge pclk) disable iff (!presetn) // RL12
    $rose(sel_ext_q) |-> $past(!int_clk && !clock_input_pin))
    else $error("mux moved while a source was high");
  chk_xtal_pin: assert property (@(posedge pclk) disable iff (!presetn) // RL17
    src_q == OCS_SRC_XTAL |=> pin_q.oe && pin_q.out == !$past(clock_input_pin))
    else $error("second pin not amplifier output");
  chk_ext_pin: assert property (@(posedge pclk) disable iff (!presetn) // RL16
    src_q == OCS_SRC_EXT |=> pin_q.out == $past(port_a_bit_four_out))
    else $error("second pin not port bit in direct mode");
  chk_stop_halt: assert property (@(posedge pclk) disable iff (!presetn) // RL21
    stop_mode [*2] |-> !full_q && $stable(half_q))
    else $error("clocks run in stop mode");
  chk_req_locked: assert property (@(posedge pclk) disable iff (!presetn) // RL22
    engaged_q && wr_stat |=> req_q == $past(req_q))
    else $error("request changed after engage");
  chk_half_rate: assert property (@(posedge pclk) disable iff (!presetn) // RL15
    $changed(half_q) |-> $rose(full_q))
    else $error("half-rate toggled without full-rate edge");

  cov_switch_done: cover property (@(posedge pclk) disable iff (!presetn)
    $rose(engaged_q));
  cov_xtal_mode: cover property (@(posedge pclk) disable iff (!presetn)
    src_q == OCS_SRC_XTAL && pin_q.oe);
  cov_clock_out: cover property (@(posedge pclk) disable iff (!presetn)
    src_q == OCS_SRC_RC && cko_en_q && $rose(pin_q.out));
  cov_stop: cover property (@(posedge pclk) disable iff (!presetn)
    $fell(full_q) && stop_mode);

endmodule

/* tb/ocs_ext_src_model.sv */
// external clock source model driving the first oscillator pin
module ocs_ext_src_model #(
  parameter real half_ns = 12.5,
  parameter real skew_ns = 1.2
) (
  input wire logic run,
  output logic clk_o
);
  timeunit 1ns;
  timeprecision 100ps;

  // free running while on; parked low while off so a dead source shows no edges
  // skew keeps every pin edge off the pclk edges, so no sampling race
  always begin
    if (run) begin
      #(half_ns) clk_o = ~clk_o;
    end else begin
      clk_o = 1'b0;
      @(run);
      #(skew_ns);
    end
  end
endmodule

/* tb/ocs_osc_switch_bench.sv */
// self-checking bench for the oscillator source switch
module ocs_osc_switch_bench import ocs_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic stop_mode = 1'b0;
  logic ext_run = 1'b0; // far-side source on
  logic pa_out = 1'b0; // port logic's wish for pin two
  logic pa_oe = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, pin2_o, pin2_oe, pin1_clk, osc_run;
  logic full_clk, half_clk, bus_clk, engaged, ext_clk;
  logic [31:0] rd; // last read data
  logic er; // last error response
  int failures = 0;
  int compares = 0;
  int cyc = 0;
  int mdl[int]; // expected register contents by byte address
  int mdl_eng = 0; // expected engaged state

  ocs_osc_switch ocs_osc_switch_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .clock_input_pin(ext_clk),
    .port_a_bit_four_out(pa_out), .port_a_bit_four_oe(pa_oe), .stop_mode(stop_mode),
    .clock_output_pin_o(pin2_o), .clock_output_pin_oe(pin2_oe),
    .clock_input_pin_is_clock(pin1_clk), .internal_osc_run(osc_run),
    .full_rate_clock(full_clk), .half_rate_clock(half_clk), .bus_clock(bus_clk),
    .external_clock_engaged(engaged));

  ocs_ext_src_model ocs_ext_src_model_i (.run(ext_run), .clk_o(ext_clk));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // hang guard, far above the roughly 1300 cycles the tests need
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      summarize();
    end
  end

  task automatic summarize;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one apb transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // register model after reset
  task automatic mreset;
    mdl[OCS_TRIM_OFS] = 32'h0000_0080;
    mdl[OCS_STAT_OFS] = 0;
    mdl[OCS_CFG_OFS] = 0;
    mdl[OCS_PUE_OFS] = 0;
    mdl_eng = 0;
  endtask

  // write and track in the model; request is frozen once engaged
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == OCS_STAT_OFS) begin
      mdl[a] = mdl_eng ? 3 : d & 1;
    end else if (mdl.exists(a)) begin
      mdl[a] = d & (a == OCS_TRIM_OFS ? 255 : a == OCS_CFG_OFS ? 3 : 1);
    end
  endtask

  // read and compare with the model; unmapped reads 0 with error
  task automatic rchk(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, mdl.exists(a) ? mdl[a] : 0);
    check(er, !mdl.exists(a));
  endtask

  // wait for the switch to finish; limit only guards a stuck sequencer
  task automatic wait_eng;
    int n;
    n = 0;
    while (engaged !== 1'b1 && n < 300) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (full_clk !== v && n < 100) begin
      @(posedge pclk);
      n++;
    end
  endtask

  // high time of a settled full-rate period, in pclk cycles
  task automatic hi_time(output int c);
    c = 0;
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    wait_lvl(1'b1);
    while (full_clk === 1'b1 && c < 100) begin
      @(posedge pclk);
      c++;
    end
  endtask

  // rising edges of full, half, bus clocks and the source pin over n cycles
  task automatic rises(input int n, output int f, output int h, output int b, output int p);
    logic [3:0] pv, cv;
    {f, h, b, p} = '0;
    pv = {full_clk, half_clk, bus_clk, ext_clk};
    repeat (n) begin
      @(posedge pclk);
      cv = {full_clk, half_clk, bus_clk, ext_clk};
      f += int'(cv[3] && !pv[3]);
      h += int'(cv[2] && !pv[2]);
      b += int'(cv[1] && !pv[1]);
      p += int'(cv[0] && !pv[0]);
      pv = cv;
    end
  endtask

  initial begin
    int c, f, h, b, p, k;
    logic xo;
    logic [7:0] tv[4];
    logic [7:0] offs[5];
    offs = '{OCS_TRIM_OFS, OCS_STAT_OFS, OCS_CFG_OFS, OCS_PUE_OFS, 8'h50};
    void'($urandom(32'h44ba_b31f));
    mreset();
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(osc_run, 1'b1);
    check(engaged, 1'b0);
    check(pin1_clk, 1'b0);
    foreach (offs[i]) rchk(offs[i]);
    $display("test reset values done");
    // trim steers the internal period, larger is longer
    tv = '{8'h00, 8'h80, 8'he0, 8'h00};
    tv[3] = 8'($urandom);
    foreach (tv[i]) begin
      wr(OCS_TRIM_OFS, tv[i]);
      rchk(OCS_TRIM_OFS);
      hi_time(c);
      check(c, 3 + tv[i][7:5]);
    end
    wr(OCS_TRIM_OFS, 32'h0000_0000);
    rises(400, f, h, b, p);
    check(b * 4 >= f - 4 && b * 4 <= f + 4, 1'b1);
    wr(OCS_TRIM_OFS, 32'h0000_0080);
    $display("test trim done");
    // second pin function for every source and enable value
    for (int s = 0; s < 4; s++) begin
      for (int e = 0; e < 2; e++) begin
        // crystal precharge: pin two driven high as a port output first
        if (s == 3 && e == 0) begin
          wr(OCS_PUE_OFS, 0);
          pa_out <= 1'b1;
          pa_oe <= 1'b1;
          repeat (4) @(posedge pclk);
          check(pin2_oe & pin2_o, 1'b1);
        end
        wr(OCS_CFG_OFS, s);
        wr(OCS_PUE_OFS, e);
        pa_out <= 1'($urandom);
        pa_oe <= 1'($urandom);
        repeat (3) @(posedge pclk);
        xo = (s == 3 || (s != 1 && e == 1)) ? 1'b1 : pa_oe;
        check(pin2_oe, xo);
        if (s == 3) begin
          check(pin2_o, 1'b1);
        end else if (s == 1 || e == 0) begin
          check(pin2_o, pa_out);
        end else begin
          check(pin2_o, full_clk);
        end
        check(pin1_clk, s != 0);
      end
    end
    $display("test pin mux done");
    // stop mode holds the full-rate clock low
    stop_mode <= 1'b1;
    repeat (3) @(posedge pclk);
    k = 0;
    repeat (30) begin
      @(posedge pclk);
      k += int'(full_clk !== 1'b0);
    end
    check(k, 0);
    stop_mode <= 1'b0;
    $display("test stop done");
    // request with a dead source must not switch
    wr(OCS_CFG_OFS, 1);
    wr(OCS_STAT_OFS, 1);
    repeat (40) @(posedge pclk);
    check(engaged, 1'b0);
    check(osc_run, 1'b1);
    ext_run <= 1'b1;
    wait_eng();
    check(engaged, 1'b1);
    check(osc_run, 1'b1);
    @(posedge pclk);
    check(osc_run, 1'b0);
    mdl_eng = 1;
    mdl[OCS_STAT_OFS] = 3;
    rises(200, f, h, b, p);
    check(f >= p - 1 && f <= p + 1, 1'b1);
    check(h * 2 >= f - 2 && h * 2 <= f + 2, 1'b1);
    check(b * 4 >= f - 4 && b * 4 <= f + 4, 1'b1);
    wr(OCS_STAT_OFS, 0);
    rchk(OCS_STAT_OFS);
    wr(OCS_CFG_OFS, 0);
    check(engaged, 1'b1);
    // source dies: no fallback to the internal oscillator
    ext_run <= 1'b0;
    repeat (50) @(posedge pclk);
    rises(40, f, h, b, p);
    check(f, 0);
    check(osc_run, 1'b0);
    check(engaged, 1'b1);
    $display("test switch done");
    // reset in mid-run restores the internal source
    presetn <= 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    mreset();
    @(posedge pclk);
    check(osc_run, 1'b1);
    check(engaged, 1'b0);
    rchk(OCS_TRIM_OFS);
    rchk(OCS_STAT_OFS);
    $display("test second reset done");
    // crystal start-up: precharge, select, let the source settle, then request
    pa_out <= 1'b1;
    pa_oe <= 1'b1;
    repeat (4) @(posedge pclk);
    wr(OCS_CFG_OFS, 3);
    ext_run <= 1'b1;
    repeat (64) @(posedge pclk);
    wr(OCS_STAT_OFS, 1);
    wait_eng();
    check(engaged, 1'b1);
    mdl_eng = 1;
    mdl[OCS_STAT_OFS] = 3;
    rchk(OCS_STAT_OFS);
    rises(100, f, h, b, p);
    check(f >= p - 1 && f <= p + 1, 1'b1);
    check(pin2_oe, 1'b1);
    $display("test crystal switch done");
    summarize();
  end
endmodule
